// *** rtl/pti_pkg.sv ***
// Package: constants and carriers for the pulse timer interrupt and emergency stop block
package pti_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_THREE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_PERIOD_VALUE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_DEAD_TIME_A = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DEAD_TIME_B = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CAPTURE = 8'h18;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int C1_TRIGGER_MODE = 0;
    localparam int C1_TRIGGER_EDGE_SELECT = 1;
    localparam int C1_CAPTURE_MODE = 2;
    localparam int C1_CLEAR_MODE = 3;
    localparam int C1_OUT1_INITIAL_LEVEL = 4;
    localparam int C1_OUT2_INITIAL_LEVEL = 5;
    localparam int C1_W = 6;
    localparam int C2_EMERGENCY_INPUT_ENABLE = 0;
    localparam int C2_EMERGENCY_STOP_RELEASE = 7;
    localparam int C3_TIMER_RUN_BIT = 0;
    localparam int C3_STOP_MODE_LSB = 1;
    localparam int C3_EMERGENCY_STOP_FLAG = 3;
    localparam int C3_COUNTER_BUSY = 4;

    // ************************************************************
    // Reset values and encodings
    // ************************************************************
    localparam logic [C1_W-1:0] CONTROL_ONE_RESET = 6'h00;
    localparam logic EMERGENCY_INPUT_ENABLE_RESET = 1'b0;
    localparam logic TIMER_RUN_RESET = 1'b0;
    localparam logic [1:0] STOP_MODE_INIT = 2'h0;
    localparam logic [1:0] STOP_MODE_HOLD = 2'h1;
    localparam logic [1:0] STOP_MODE_PERIOD_END = 2'h2;

    // ************************************************************
    // Timing, in high-frequency clock periods
    // ************************************************************
    localparam int EMERGENCY_MIN_LOW_FC = 4;
    localparam int EMERGENCY_RESPONSE_MAX_FC = 10;
    localparam int SYNC_STAGES = 3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } pti_apb_req_type;

    typedef struct packed {
        logic trigger_start_irq;
        logic period_irq;
        logic emergency_stop_irq;
    } pti_irq_type;

endpackage

// *** rtl/pti_pulse_timer.sv ***
// Module: pulse timer with interrupt sources and emergency output stop
//
// Contract
// - Trigger-start interrupt when a selected trigger edge starts the counter.
// - No trigger-start interrupt for count-clearing edges or in capture mode.
// - Trigger-start interrupt still raised during the emergency stop state.
// - Period interrupt on command start and at period match with clear.
// - Period interrupt on match still raised during emergency stop state.
// - Run write at trigger stop level waits; later start edge starts and interrupts.
// - Emergency input enable accepts pin at 1, ignores at 0, resets to 0.
// - Enabled low emergency input forces outputs to initial levels and interrupts.
// - Emergency stop disables outputs only; counter keeps running.
// - Emergency input sampled on the high-frequency clock.
// - Emergency flag set on activation; reads 1 while outputs disabled.
// - Release write ends emergency only with run 0 and stop mode 00.
// - Release with pin low and enabled re-enters emergency and interrupts again.
// - Emergency interrupt on every accepted input whether or not timer runs.
// - Timer cannot restart while emergency state is active.
// - Outputs reach initial levels within ten clock periods of low detection.
// - Low-power chip mode initializes and halts the timer.
// - Stop mode 00 with run cleared stops counter, outputs to initial levels.
// - Initial level 0 starts low, goes high at dead-time match; 1 inverts.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module pti_pulse_timer #(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire pti_pkg::pti_apb_req_type apb_req,
    output logic [pti_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic trigger_pin,
    input wire logic emergency_stop_pin_n,
    input wire logic chip_low_power,
    output logic pulse_out_a,
    output logic pulse_out_b,
    output pti_pkg::pti_irq_type irq
);
    import pti_pkg::*;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [C1_W-1:0] timer_control_one;
    logic emergency_input_enable;
    logic timer_run_bit;
    logic [1:0] stop_mode_select;
    logic emergency_stop_flag;
    logic [CNT_W-1:0] period_value;
    logic [CNT_W-1:0] dead_time_a;
    logic [CNT_W-1:0] dead_time_b;
    logic [CNT_W-1:0] capture_value;
    logic [CNT_W-1:0] count;
    logic counting;
    logic phase_a;
    logic phase_b;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic bus_write;
    logic wr_one;
    logic wr_two;
    logic wr_three;
    logic [DATA_W-1:0] wdata;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == OFS_CONTROL_ONE) || (a == OFS_CONTROL_TWO) || (a == OFS_CONTROL_THREE)
            || (a == OFS_PERIOD_VALUE) || (a == OFS_DEAD_TIME_A) || (a == OFS_DEAD_TIME_B)
            || (a == OFS_CAPTURE);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
        widen = DATA_W'(v);
    endfunction

    assign bus_write = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
    assign wdata = apb_req.pwdata;
    assign wr_one = bus_write && (apb_req.paddr == OFS_CONTROL_ONE);
    assign wr_two = bus_write && (apb_req.paddr == OFS_CONTROL_TWO);
    assign wr_three = bus_write && (apb_req.paddr == OFS_CONTROL_THREE);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [SYNC_STAGES-1:0] trig_sync;
    logic [SYNC_STAGES-1:0] emg_sync;
    logic trig_level;
    logic trig_level_prev;
    logic trig_active;
    logic emg_low;

    // Last two stages must agree before a level counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_sync <= '0;
            trig_level <= 1'b0;
            trig_level_prev <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[SYNC_STAGES-2:0], trigger_pin};
            if (trig_sync[SYNC_STAGES-1] == trig_sync[SYNC_STAGES-2]) begin
                trig_level <= trig_sync[SYNC_STAGES-1];
            end
            trig_level_prev <= trig_level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emg_sync <= '1;
            emg_low <= 1'b0;
        end else begin
            emg_sync <= {emg_sync[SYNC_STAGES-2:0], emergency_stop_pin_n};
            if (emg_sync[SYNC_STAGES-1] == emg_sync[SYNC_STAGES-2]) begin
                emg_low <= ~emg_sync[SYNC_STAGES-1];
            end
        end
    end

    // ************************************************************
    // Event decode
    // ************************************************************
    logic start_edge;
    logic trig_mode;
    logic capture_mode;
    logic clear_mode;
    logic run_rise;
    logic cmd_start;
    logic trig_start_evt;
    logic clear_evt;
    logic period_end;
    logic start_now;
    logic stop_init;
    logic stop_hold;
    logic release_ok;
    logic emg_set;

    assign trig_mode = timer_control_one[C1_TRIGGER_MODE];
    assign capture_mode = timer_control_one[C1_CAPTURE_MODE];
    assign clear_mode = timer_control_one[C1_CLEAR_MODE];
    assign trig_active = trig_level ^ timer_control_one[C1_TRIGGER_EDGE_SELECT];
    // Edge taken from the level, so an edge select write starts nothing
    assign start_edge = trig_active && (trig_level != trig_level_prev);
    assign run_rise = wr_three && wdata[C3_TIMER_RUN_BIT] && !timer_run_bit && !emergency_stop_flag;
    assign cmd_start = run_rise && (!trig_mode || trig_active);
    assign trig_start_evt = timer_run_bit && trig_mode && !capture_mode && !clear_mode
        && start_edge && !counting;
    assign clear_evt = timer_run_bit && trig_mode && clear_mode && start_edge && counting;
    assign period_end = counting && (count == period_value);
    assign start_now = (cmd_start || (trig_start_evt && !emergency_stop_flag)) && !chip_low_power;
    assign stop_init = wr_three && !wdata[C3_TIMER_RUN_BIT]
        && (wdata[C3_STOP_MODE_LSB +: 2] == STOP_MODE_INIT);
    assign stop_hold = wr_three && !wdata[C3_TIMER_RUN_BIT]
        && (wdata[C3_STOP_MODE_LSB +: 2] == STOP_MODE_HOLD);
    assign release_ok = wr_two && wdata[C2_EMERGENCY_STOP_RELEASE] && !timer_run_bit
        && (stop_mode_select == STOP_MODE_INIT);
    assign emg_set = emergency_input_enable && emg_low && (!emergency_stop_flag || release_ok);

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_one <= CONTROL_ONE_RESET;
            emergency_input_enable <= EMERGENCY_INPUT_ENABLE_RESET;
            timer_run_bit <= TIMER_RUN_RESET;
            stop_mode_select <= STOP_MODE_INIT;
            period_value <= '0;
            dead_time_a <= '0;
            dead_time_b <= '0;
        end else if (chip_low_power) begin
            timer_control_one <= CONTROL_ONE_RESET;
            emergency_input_enable <= EMERGENCY_INPUT_ENABLE_RESET;
            timer_run_bit <= TIMER_RUN_RESET;
            stop_mode_select <= STOP_MODE_INIT;
            period_value <= '0;
            dead_time_a <= '0;
            dead_time_b <= '0;
        end else begin
            if (wr_one) begin
                timer_control_one <= wdata[C1_W-1:0];
            end
            if (wr_two) begin
                emergency_input_enable <= wdata[C2_EMERGENCY_INPUT_ENABLE];
            end
            if (wr_three) begin
                timer_run_bit <= wdata[C3_TIMER_RUN_BIT] && (timer_run_bit || !emergency_stop_flag);
                stop_mode_select <= wdata[C3_STOP_MODE_LSB +: 2];
            end
            if (bus_write && apb_req.paddr == OFS_PERIOD_VALUE) begin
                period_value <= wdata[CNT_W-1:0];
            end
            if (bus_write && apb_req.paddr == OFS_DEAD_TIME_A) begin
                dead_time_a <= wdata[CNT_W-1:0];
            end
            if (bus_write && apb_req.paddr == OFS_DEAD_TIME_B) begin
                dead_time_b <= wdata[CNT_W-1:0];
            end
        end
    end

    // ************************************************************
    // Emergency stop state
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emergency_stop_flag <= 1'b0;
        // Set wins over a release in the same cycle
        end else if (emg_set) begin
            emergency_stop_flag <= 1'b1;
        end else if (release_ok) begin
            emergency_stop_flag <= 1'b0;
        end
    end

    // ************************************************************
    // Counter
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counting <= 1'b0;
            count <= '0;
        end else if (chip_low_power) begin
            counting <= 1'b0;
            count <= '0;
        end else if (start_now) begin
            counting <= 1'b1;
            count <= '0;
        end else if (stop_init || stop_hold) begin
            counting <= 1'b0;
            count <= '0;
        end else if (period_end) begin
            count <= '0;
            if (!timer_run_bit || stop_mode_select == STOP_MODE_PERIOD_END) begin
                counting <= 1'b0;
            end
        end else if (clear_evt) begin
            count <= '0;
        end else if (counting) begin
            count <= count + CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value <= '0;
        end else if (timer_run_bit && trig_mode && capture_mode && start_edge) begin
            capture_value <= count;
        end
    end

    // ************************************************************
    // Output phases
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_a <= 1'b0;
            phase_b <= 1'b0;
        end else if (chip_low_power || start_now || stop_init || period_end || clear_evt) begin
            phase_a <= 1'b0;
            phase_b <= 1'b0;
        end else if (counting) begin
            if (count == dead_time_a) begin
                phase_a <= 1'b1;
            end
            if (count == dead_time_b) begin
                phase_b <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_out_a <= 1'b0;
            pulse_out_b <= 1'b0;
        end else begin
            // Emergency masks the phases only; the counter runs on
            pulse_out_a <= timer_control_one[C1_OUT1_INITIAL_LEVEL] ^ (phase_a && !emergency_stop_flag);
            pulse_out_b <= timer_control_one[C1_OUT2_INITIAL_LEVEL] ^ (phase_b && !emergency_stop_flag);
        end
    end

    // ************************************************************
    // Interrupt pulses
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= '0;
        end else begin
            irq.trigger_start_irq <= trig_start_evt && !chip_low_power;
            irq.period_irq <= (cmd_start && !chip_low_power) || period_end;
            irq.emergency_stop_irq <= emg_set;
        end
    end

    // ************************************************************
    // Bus answer
    // ************************************************************
    function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        unique case (a)
            OFS_CONTROL_ONE: v[C1_W-1:0] = timer_control_one;
            OFS_CONTROL_TWO: v[C2_EMERGENCY_INPUT_ENABLE] = emergency_input_enable;
            OFS_CONTROL_THREE: begin
                v[C3_TIMER_RUN_BIT] = timer_run_bit;
                v[C3_STOP_MODE_LSB +: 2] = stop_mode_select;
                v[C3_EMERGENCY_STOP_FLAG] = emergency_stop_flag;
                v[C3_COUNTER_BUSY] = counting;
            end
            OFS_PERIOD_VALUE: v = widen(period_value);
            OFS_DEAD_TIME_A: v = widen(dead_time_a);
            OFS_DEAD_TIME_B: v = widen(dead_time_b);
            OFS_CAPTURE: v = widen(capture_value);
            default: v = '0;
        endcase
        reg_read = v;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_req.psel && !apb_req.penable;
            pslverr <= apb_req.psel && !apb_req.penable && !addr_hit(apb_req.paddr);
            if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
                prdata <= reg_read(apb_req.paddr);
            end else begin
                prdata <= '0;
            end
        end
    end

endmodule // pti_pulse_timer

// *** tb/pti_fault_src.sv ***
// Model: external fault source that pulls the emergency input low
`timescale 1ns/1ps
module pti_fault_src (
    input wire logic pclk,
    input wire logic fire,
    input wire logic hold_low,
    input wire logic [7:0] low_cycles,
    output logic emergency_stop_pin_n
);
    logic [7:0] left;

    initial left = 8'h00;

    // Low span counter, low for exactly as many cycles as commanded
    always @(posedge pclk) begin
        if (fire) begin
            left <= low_cycles;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end

    // Pin idles high
    assign emergency_stop_pin_n = !(hold_low || left != 8'h00);
endmodule // pti_fault_src

// *** tb/pti_pulse_timer_sva.sv ***
// Checker: bus and emergency stop properties of the pulse timer
`timescale 1ns/1ps
module pti_pulse_timer_sva
    import pti_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire pti_pkg::pti_apb_req_type apb_req,
    input wire logic [pti_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trigger_pin,
    input wire logic emergency_stop_pin_n,
    input wire logic chip_low_power,
    input wire logic pulse_out_a,
    input wire logic pulse_out_b,
    input wire pti_pkg::pti_irq_type irq
);
    // ************************************************************
    // Register mirror
    // ************************************************************
    logic commit, en, run, tmode, cap, ina, inb, in_emg, release_ok, cmd_start, stop_init;
    logic [1:0] mode;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    assign commit = apb_req.psel && apb_req.penable && pready && apb_req.pwrite && !pslverr;
    assign release_ok = commit && apb_req.paddr == OFS_CONTROL_TWO && apb_req.pwdata[7] && !run && mode == 2'h0;
    assign cmd_start = commit && apb_req.paddr == OFS_CONTROL_THREE && apb_req.pwdata[0] && !run && !tmode && !in_emg;
    assign stop_init = commit && apb_req.paddr == OFS_CONTROL_THREE && apb_req.pwdata[2:0] == 3'h0 && run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tmode, cap, ina, inb, en, run, mode} <= '0;
        end else if (chip_low_power) begin
            {tmode, cap, ina, inb, en, run, mode} <= '0;
        end else if (commit && apb_req.paddr == OFS_CONTROL_ONE) begin
            {inb, ina, cap, tmode} <= {apb_req.pwdata[5:4], apb_req.pwdata[2], apb_req.pwdata[0]};
        end else if (commit && apb_req.paddr == OFS_CONTROL_TWO) begin
            en <= apb_req.pwdata[0];
        end else if (commit && apb_req.paddr == OFS_CONTROL_THREE) begin
            run <= apb_req.pwdata[0] && !in_emg;
            mode <= apb_req.pwdata[2:1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_emg <= 1'b0;
        end else if (irq.emergency_stop_irq) begin
            in_emg <= 1'b1;
        end else if (release_ok) begin
            in_emg <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_rdata_idle_zero: assert property (!pready |-> prdata == '0)
        else $error("read data not zero outside access");
    a_trig_irq_pulse: assert property (irq.trigger_start_irq |=> !irq.trigger_start_irq)
        else $error("trigger start request longer than one cycle");
    a_trig_not_capture: assert property (irq.trigger_start_irq |-> !cap && !$past(cap))
        else $error("trigger start request in capture mode");
    a_emg_needs_enable: assert property (irq.emergency_stop_irq |-> en || $past(en))
        else $error("emergency request while input disabled");
    a_emg_response: assert property ((en && !in_emg && $fell(emergency_stop_pin_n)) ##1
        !emergency_stop_pin_n [*3] |-> ##[1:7] irq.emergency_stop_irq)
        else $error("emergency request late or missing");
    a_outs_forced: assert property (in_emg && $past(in_emg) |-> {pulse_out_b, pulse_out_a} == {inb, ina})
        else $error("outputs not at initial levels in emergency");
    a_cmd_start_irq: assert property (cmd_start |-> ##[1:3] irq.period_irq)
        else $error("no period request on command start");
    a_stop_init_outs: assert property (stop_init |-> ##[1:3] {pulse_out_b, pulse_out_a} == {inb, ina})
        else $error("outputs not initial after stop");
    a_low_power_quiet: assert property (chip_low_power [*3] |-> !pulse_out_a && !pulse_out_b && !irq.period_irq)
        else $error("timer active in low power mode");

    c_emg: cover property (irq.emergency_stop_irq);
    c_trig: cover property (irq.trigger_start_irq);
    c_per_in_emg: cover property (irq.period_irq && in_emg);
endmodule // pti_pulse_timer_sva

bind pti_pulse_timer pti_pulse_timer_sva #(.CNT_W(CNT_W)) pti_pulse_timer_sva_i (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin),
    .emergency_stop_pin_n(emergency_stop_pin_n), .chip_low_power(chip_low_power), .pulse_out_a(pulse_out_a),
    .pulse_out_b(pulse_out_b), .irq(irq));

// *** tb/testbench.sv ***
// Testbench: register-level scenarios for the pulse timer emergency stop and interrupts
`timescale 1ns/1ps
module testbench;
    import pti_pkg::*;
    logic pclk, presetn, trigger_pin, chip_low_power, fire, hold_low, emergency_stop_pin_n;
    logic pulse_out_a, pulse_out_b, pready, pslverr, err;
    logic [7:0] low_cycles;
    logic [DATA_W-1:0] prdata, rd;
    pti_apb_req_type apb_req;
    pti_irq_type irq;
    int mismatches, compares, n_trig, n_per, n_emg, base;

    pti_pulse_timer pti_pulse_timer_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trigger_pin(trigger_pin), .emergency_stop_pin_n(emergency_stop_pin_n),
        .chip_low_power(chip_low_power), .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b), .irq(irq));
    pti_fault_src pti_fault_src_i (.pclk(pclk), .fire(fire), .hold_low(hold_low), .low_cycles(low_cycles),
        .emergency_stop_pin_n(emergency_stop_pin_n));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Interrupt pulse counters
    always @(posedge pclk) begin
        if (irq.trigger_start_irq === 1'b1) n_trig++;
        if (irq.period_irq === 1'b1) n_per++;
        if (irq.emergency_stop_irq === 1'b1) n_emg++;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic print_verdict();
        if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        int k;
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= addr;
        apb_req.pwdata <= data;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        if (k >= 20) begin
            mismatches++;
            print_verdict();
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic pulse_low(input logic [7:0] len);
        low_cycles <= len;
        fire <= 1'b1;
        @(posedge pclk);
        fire <= 1'b0;
    endtask

    initial begin
        #(20 * 3000);
        mismatches++;
        print_verdict();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        presetn = 1'b0;
        apb_req = '0;
        trigger_pin = 1'b0;
        chip_low_power = 1'b0;
        fire = 1'b0;
        hold_low = 1'b0;
        low_cycles = 8'h04;
        cyc(4);
        presetn <= 1'b1;
        cyc(1);
        xfer(1'b0, OFS_CONTROL_TWO, '0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h40, '0);
        chk({31'h0, err}, 32'h1);
        pulse_low(8'h06);
        cyc(14);
        chk(n_emg, 0);
        xfer(1'b1, OFS_PERIOD_VALUE, 32'h5);
        xfer(1'b1, OFS_DEAD_TIME_A, 32'h2);
        xfer(1'b1, OFS_DEAD_TIME_B, 32'h3);
        xfer(1'b1, OFS_CONTROL_ONE, 32'h10);
        cyc(2);
        chk({pulse_out_b, pulse_out_a}, 2'b01);
        base = n_per;
        xfer(1'b1, OFS_CONTROL_THREE, 32'h1);
        cyc(3);
        chk(n_per - base, 1);
        cyc(12);
        chk(n_per - base >= 2, 1);
        // Emergency while running
        xfer(1'b1, OFS_CONTROL_TWO, 32'h1);
        base = n_emg;
        pulse_low(8'h04);
        cyc(10);
        chk(n_emg - base, 1);
        chk({pulse_out_b, pulse_out_a}, 2'b01);
        base = n_per;
        xfer(1'b0, OFS_CONTROL_THREE, '0);
        chk(rd[4:0], 5'h19);
        cyc(14);
        chk(n_per > base, 1);
        chk({pulse_out_b, pulse_out_a}, 2'b01);
        // Release refused, restart refused
        xfer(1'b1, OFS_CONTROL_THREE, 32'h2);
        xfer(1'b1, OFS_CONTROL_TWO, 32'h81);
        xfer(1'b1, OFS_CONTROL_THREE, 32'h1);
        xfer(1'b0, OFS_CONTROL_THREE, '0);
        chk(rd[3:0], 4'h8);
        // Release with pin still low
        hold_low <= 1'b1;
        cyc(8);
        base = n_emg;
        xfer(1'b1, OFS_CONTROL_TWO, 32'h81);
        cyc(2);
        chk(n_emg - base, 1);
        xfer(1'b0, OFS_CONTROL_THREE, '0);
        chk(rd[3], 1'b1);
        hold_low <= 1'b0;
        cyc(8);
        xfer(1'b1, OFS_CONTROL_TWO, 32'h81);
        xfer(1'b0, OFS_CONTROL_THREE, '0);
        chk(rd[3], 1'b0);
        // Trigger start after a run write at stop level
        xfer(1'b1, OFS_CONTROL_TWO, 32'h1);
        base = n_per;
        xfer(1'b1, OFS_CONTROL_ONE, 32'h11);
        xfer(1'b1, OFS_CONTROL_THREE, 32'h1);
        cyc(8);
        chk(n_per - base, 0);
        base = n_trig;
        trigger_pin <= 1'b1;
        cyc(8);
        chk(n_trig - base, 1);
        trigger_pin <= 1'b0;
        xfer(1'b1, OFS_CONTROL_THREE, '0);
        cyc(2);
        chk({pulse_out_b, pulse_out_a}, 2'b01);
        // Trigger start during emergency
        xfer(1'b1, OFS_CONTROL_THREE, 32'h1);
        pulse_low(8'h04);
        cyc(10);
        base = n_trig;
        trigger_pin <= 1'b1;
        cyc(8);
        chk(n_trig - base, 1);
        xfer(1'b0, OFS_CONTROL_THREE, '0);
        chk(rd[4:3], 2'b01);
        trigger_pin <= 1'b0;
        xfer(1'b1, OFS_CONTROL_THREE, '0);
        xfer(1'b1, OFS_CONTROL_TWO, 32'h81);
        // Capture mode edges
        xfer(1'b1, OFS_CONTROL_ONE, 32'h15);
        xfer(1'b1, OFS_CONTROL_THREE, 32'h1);
        base = n_trig;
        trigger_pin <= 1'b1;
        cyc(8);
        trigger_pin <= 1'b0;
        cyc(8);
        chk(n_trig - base, 0);
        // Low power entry
        xfer(1'b1, OFS_CONTROL_THREE, '0);
        chip_low_power <= 1'b1;
        cyc(4);
        chk({pulse_out_b, pulse_out_a}, 2'b00);
        chip_low_power <= 1'b0;
        cyc(1);
        xfer(1'b0, OFS_CONTROL_THREE, '0);
        chk(rd[4:0], 5'h0);
        xfer(1'b0, OFS_CONTROL_ONE, '0);
        chk(rd, 32'h0);
        print_verdict();
    end
endmodule // testbench
